// ---- include/hmp_pkg.sv ----
// Package of constants and types for the host mailbox port.
package hmp_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int          CORE_AW        = 14;
	localparam logic [13:0] MBX_BASE_ADDR  = 14'h3fe0;
	localparam logic [13:0] MBX_LAST_ADDR  = 14'h3fe5;
	localparam int          NUM_DATA_REGS  = 6;
	localparam logic [2:0]  IDX_WR_FLAGS   = 3'h6;
	localparam logic [2:0]  IDX_MIRROR_CTL = 3'h7;

	// ****************************************************************
	// Status fields
	// ****************************************************************
	localparam int         HOST_FLAGS_LSB = 0;
	localparam int         CORE_FLAGS_LSB = 8;
	localparam int         MIRROR_LSB     = 0;
	localparam int         SWRST_BIT      = 6;
	localparam int         OVWR_BIT       = 7;
	localparam logic       OVWR_RESET     = 1'b1;
	localparam logic [5:0] FLAGS_RESET    = 6'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS     = 4000;
	localparam int SWRST_CYCLES      = 5;
	localparam int SYNC_STAGES       = 2;
	localparam int FIFO_DEPTH        = 32;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		HST_IDLE,
		HST_HOLD,
		HST_ACKED
	} hmp_host_state_e;

	// Index of a core address in the mailbox window with bit 3 set, or zero if outside.
	function automatic logic [3:0] core_index(input logic [13:0] addr);
		core_index = (addr[13:3] == MBX_BASE_ADDR[13:3]) ? {1'b1, addr[2:0]} : 4'h0;
	endfunction : core_index

endpackage : hmp_pkg

// ---- src/hmp_top.sv ----
// Host mailbox port: host pin interface, shared mailbox registers, status and write FIFO.
`timescale 1ns/100ps

// ********************************************************************
// Write FIFO
// ********************************************************************
module hmp_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             i_mclk,
	input  wire logic             i_nrst,
	input  wire logic             i_ce,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data  = mem[rd_ptr_reg];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_ff @(posedge i_mclk) begin
		if (i_ce && push) begin
			mem[wr_ptr_reg] <= i_in_data;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else if (i_ce) begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : hmp_fifo

// ********************************************************************
// Port top
// ********************************************************************
// Function
// (RULE1) Six mailbox data registers sit at consecutive core addresses from the base.
// (RULE2) Host and core may both read and write every data register.
// (RULE3) Host reads and writes of data registers raise read and write requests.
// (RULE4) Host write sets a low-byte flag, held until the core reads it.
// (RULE5) Core write sets a high-byte flag, cleared when the host reads it.
// (RULE6) Second status low six bits mirror the core-written flags.
// (RULE7) Second status bit 7 is overwrite enable, bit 6 software reset.
// (RULE8) Reserved and software-reset bits read zero; only overwrite bit reads back.
// (RULE9) Reset clears all status bits except overwrite enable, which becomes one.
// (RULE10) Acknowledge comes with the access unless a write is held off.
// (RULE11) No reset alters mailbox data contents.
// (RULE12) During reset no transfers, acknowledge low, data pins released.
// (RULE13) Simultaneous host and core writes to one register: host wins.
// (RULE14) Status seen by either party stays stable for the whole read.
// (RULE15) Host status reads return status one synchronisation step old.
// (RULE16) Host reads status twice and keeps the second result.
// (RULE17) Host status updates after a low-high-low pseudo-clock sequence.
// (RULE18) Core status view follows a change after one full core clock.
// (RULE19) Overwrite off: write to unread register waits for core read.
// (RULE20) Host keeps a held-off access pending until acknowledged.
// (RULE21) Overwrite on: host write replaces data and is acknowledged at once.
// (RULE22) Hosts without acknowledge should keep overwrite enabled.
// (RULE23) Eight-bit host mode uses low byte; upper zeroed on write, released on read.
// (RULE24) Multiplexed mode decodes only the three low captured address bits.
// (RULE25) Single-strobe mode: select high means read, low means write.
// (RULE26) Software reset makes a five-cycle internal reset pulse.
// (RULE27) Host addresses 0-5 pick data registers, 6 and 7 the status registers.
module hmp_top #(
	parameter int FIFO_DEPTH = hmp_pkg::FIFO_DEPTH
) (
	// Clock, reset and enable
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	input  wire logic        i_ce,
	// Host pins
	input  wire logic        i_host_sel_n,
	input  wire logic        i_host_rw_select,
	input  wire logic        i_host_write_strobe_n,
	input  wire logic        i_host_size8,
	input  wire logic        i_host_strobe_mode,
	input  wire logic        i_host_mux_mode,
	input  wire logic        i_host_ale_addr2,
	input  wire logic [1:0]  i_host_addr,
	input  wire logic [15:0] i_host_data,
	output logic [15:0]      o_host_data,
	output logic [1:0]       o_host_data_oe,
	output logic             o_host_acknowledge,
	// Core data memory port
	input  wire logic [13:0] i_core_addr,
	input  wire logic        i_core_rd,
	input  wire logic        i_core_wr,
	input  wire logic [15:0] i_core_wdata,
	output logic [15:0]      o_core_rdata,
	// Core requests and reset
	output logic             o_read_irq_req,
	output logic             o_write_irq_req,
	output logic             o_soft_reset
);
	localparam int SW = 25;
	localparam int FW = 19;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;

	always_ff @(posedge i_mclk) begin
		if (i_ce) begin
			sync1_reg <= {i_host_sel_n, i_host_rw_select, i_host_write_strobe_n, i_host_size8,
				i_host_strobe_mode, i_host_mux_mode, i_host_ale_addr2, i_host_addr,
				i_host_data};
			sync2_reg <= sync1_reg;
		end
	end

	logic        s_sel;
	logic        s_rw;
	logic        s_wrn;
	logic        s_size8;
	logic        s_smode;
	logic        s_mux;
	logic        s_a2ale;
	logic [1:0]  s_addr;
	logic [15:0] s_data;
	logic        h_rd;
	logic        h_wr;
	logic        h_act;

	assign {s_sel, s_rw, s_wrn, s_size8, s_smode, s_mux, s_a2ale, s_addr, s_data} =
		{~sync2_reg[24], sync2_reg[23:0]};
	// Separate strobes use the first pin as active-low read strobe.
	assign h_rd  = s_sel & (s_smode ? (~s_wrn & s_rw) : ~s_rw); // RULE25
	assign h_wr  = s_sel & (s_smode ? (~s_wrn & ~s_rw) : ~s_wrn); // RULE25
	assign h_act = h_rd | h_wr;

	// ****************************************************************
	// Reset generation
	// ****************************************************************
	logic       swrst_req;
	logic [2:0] swrst_cnt_reg;
	logic       in_reset;

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			swrst_cnt_reg <= '0;
		end else if (i_ce) begin
			if (swrst_req) begin
				swrst_cnt_reg <= 3'(hmp_pkg::SWRST_CYCLES); // RULE26
			end else if (swrst_cnt_reg != '0) begin
				swrst_cnt_reg <= swrst_cnt_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_soft_reset <= 1'b0;
		end else if (i_ce) begin
			o_soft_reset <= swrst_req | (swrst_cnt_reg > 3'h1);
		end
	end

	assign in_reset = (swrst_cnt_reg != '0);

	// ****************************************************************
	// Host address capture
	// ****************************************************************
	logic [2:0] mux_addr_reg;
	logic [2:0] h_addr;

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			mux_addr_reg <= '0;
		end else if (i_ce && s_mux && s_a2ale) begin
			mux_addr_reg <= s_data[2:0]; // RULE24
		end
	end

	assign h_addr = s_mux ? mux_addr_reg : {s_a2ale, s_addr}; // RULE27

	// ****************************************************************
	// Mailbox storage and status
	// ****************************************************************
	logic [15:0] mbx [hmp_pkg::NUM_DATA_REGS];
	logic [5:0]  host_flags_reg;
	logic [5:0]  core_flags_reg;
	logic        ovwr_reg;
	logic [5:0]  rd_req_reg;
	logic [5:0]  wr_req_reg;
	logic [15:0] sr6;
	logic [15:0] sr7;

	assign sr6 = {2'h0, core_flags_reg, 2'h0, host_flags_reg};
	assign sr7 = {8'h00, ovwr_reg, 1'b0, core_flags_reg}; // RULE6 RULE7 RULE8

	// Core access decode.
	logic [3:0] cidx;
	logic       c_rd_mbx;
	logic       c_wr_mbx;

	assign cidx     = hmp_pkg::core_index(i_core_addr);
	assign c_rd_mbx = i_core_rd & cidx[3] & (cidx[2:0] < 3'(hmp_pkg::NUM_DATA_REGS)); // RULE1
	assign c_wr_mbx = i_core_wr & cidx[3] & (cidx[2:0] < 3'(hmp_pkg::NUM_DATA_REGS)); // RULE1

	// ****************************************************************
	// Host write FIFO
	// ****************************************************************
	logic          f_in_valid;
	logic [FW-1:0] f_in_data;
	logic          f_in_ready;
	logic          f_out_valid;
	logic [FW-1:0] f_out_data;
	logic          f_out_ready;
	logic          f_apply;
	logic [2:0]    f_idx;

	// A drained host write waits for as long as the core writes the same
	// register, so the host value lands last and wins the collision.
	assign f_idx       = f_out_data[18:16];
	assign f_out_ready = ~(c_wr_mbx && (cidx[2:0] == f_idx)); // RULE13
	assign f_apply     = f_out_valid & f_out_ready;

	hmp_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_mclk     (i_mclk),
		.i_nrst     (i_nrst),
		.i_ce       (i_ce),
		.i_in_valid (f_in_valid),
		.i_in_data  (f_in_data),
		.o_in_ready (f_in_ready),
		.o_out_valid(f_out_valid),
		.o_out_data (f_out_data),
		.i_out_ready(f_out_ready)
	);

	// Data registers have no reset at all.
	always_ff @(posedge i_mclk) begin
		if (i_ce) begin
			if (c_wr_mbx) begin
				mbx[cidx[2:0]] <= i_core_wdata; // RULE2 RULE11
			end
			if (f_apply && (f_idx < 3'(hmp_pkg::NUM_DATA_REGS))) begin
				mbx[f_idx] <= f_out_data[15:0]; // RULE2 RULE11 RULE21
			end
		end
	end

	// ****************************************************************
	// Host access machine
	// ****************************************************************
	hmp_pkg::hmp_host_state_e hst_reg;
	logic [2:0]  acc_addr_reg;
	logic        acc_wr_reg;
	logic        acc_size8_reg;
	logic [15:0] host_view6_reg;
	logic [15:0] host_view7_reg;
	logic        h_start;
	logic        h_end;
	logic        blocked;
	logic        host_rd_data;

	assign h_start      = (hst_reg == hmp_pkg::HST_IDLE) & h_act & ~in_reset;
	assign h_end        = (hst_reg == hmp_pkg::HST_ACKED) & ~h_act;
	assign blocked      = ~f_in_ready
		| (~ovwr_reg & (h_addr < 3'(hmp_pkg::NUM_DATA_REGS)) & host_flags_reg[h_addr]); // RULE19
	assign host_rd_data = h_start & h_rd & (h_addr < 3'(hmp_pkg::NUM_DATA_REGS));
	assign f_in_valid   = h_end & acc_wr_reg & f_in_ready;
	assign f_in_data    = {acc_addr_reg,
		acc_size8_reg ? {8'h00, s_data[7:0]} : s_data}; // RULE23
	assign swrst_req    = (f_apply & (f_idx == hmp_pkg::IDX_MIRROR_CTL)
		& f_out_data[hmp_pkg::SWRST_BIT])
		| (i_core_wr & cidx[3] & (cidx[2:0] == hmp_pkg::IDX_MIRROR_CTL)
		& i_core_wdata[hmp_pkg::SWRST_BIT]); // RULE26

	always_ff @(posedge i_mclk) begin
		if (!i_nrst || in_reset) begin
			hst_reg            <= hmp_pkg::HST_IDLE; // RULE12
			o_host_acknowledge <= 1'b0; // RULE12
			o_host_data_oe     <= 2'b00; // RULE12
			acc_addr_reg       <= '0;
			acc_wr_reg         <= 1'b0;
			acc_size8_reg      <= 1'b0;
		end else if (i_ce) begin
			case (hst_reg)
				hmp_pkg::HST_IDLE: begin
					if (h_start) begin
						acc_addr_reg  <= h_addr;
						acc_wr_reg    <= h_wr;
						acc_size8_reg <= s_size8;
						if (h_wr && blocked) begin
							hst_reg <= hmp_pkg::HST_HOLD; // RULE19 RULE20
						end else begin
							hst_reg            <= hmp_pkg::HST_ACKED;
							o_host_acknowledge <= 1'b1; // RULE10 RULE21
							o_host_data_oe     <= h_rd ? {~s_size8, 1'b1} : 2'b00; // RULE23
						end
					end
				end
				hmp_pkg::HST_HOLD: begin
					if (!h_act) begin
						hst_reg <= hmp_pkg::HST_IDLE;
					end else if (!blocked) begin
						hst_reg            <= hmp_pkg::HST_ACKED;
						o_host_acknowledge <= 1'b1; // RULE10
					end
				end
				hmp_pkg::HST_ACKED: begin
					if (!h_act) begin
						hst_reg            <= hmp_pkg::HST_IDLE;
						o_host_acknowledge <= 1'b0;
						o_host_data_oe     <= 2'b00;
					end
				end
				default: begin
					hst_reg <= hmp_pkg::HST_IDLE;
				end
			endcase
		end
	end

	// Host read data is latched at the start and held for the whole access.
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_host_data <= '0;
		end else if (i_ce && h_start && h_rd) begin
			case (h_addr)
				hmp_pkg::IDX_WR_FLAGS:   o_host_data <= host_view6_reg; // RULE14 RULE15
				hmp_pkg::IDX_MIRROR_CTL: o_host_data <= host_view7_reg; // RULE14 RULE15
				default:                 o_host_data <= mbx[h_addr];
			endcase
		end
	end

	// Host status view moves only when an access ends, so a status change
	// needs one low-high-low strobe sequence before the host can see it.
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			host_view6_reg <= '0;
			host_view7_reg <= {8'h00, hmp_pkg::OVWR_RESET, 7'h00};
		end else if (i_ce && (h_end || (hst_reg == hmp_pkg::HST_HOLD && !h_act))) begin
			host_view6_reg <= sr6; // RULE17
			host_view7_reg <= sr7; // RULE17
		end
	end

	// ****************************************************************
	// Status flags and requests
	// ****************************************************************
	logic [5:0] h_wr_set;
	logic [5:0] h_rd_hit;
	logic [5:0] c_rd_hit;
	logic [5:0] c_wr_hit;

	always_comb begin
		h_wr_set = '0;
		h_rd_hit = '0;
		c_rd_hit = '0;
		c_wr_hit = '0;
		if (f_apply && (f_idx < 3'(hmp_pkg::NUM_DATA_REGS))) begin
			h_wr_set[f_idx] = 1'b1;
		end
		if (host_rd_data) begin
			h_rd_hit[h_addr] = 1'b1;
		end
		if (c_rd_mbx) begin
			c_rd_hit[cidx[2:0]] = 1'b1;
		end
		if (c_wr_mbx) begin
			c_wr_hit[cidx[2:0]] = 1'b1;
		end
	end

	// Setting wins over a clear that lands in the same cycle.
	always_ff @(posedge i_mclk) begin
		if (!i_nrst || in_reset) begin
			host_flags_reg <= hmp_pkg::FLAGS_RESET; // RULE9
			core_flags_reg <= hmp_pkg::FLAGS_RESET; // RULE9
			rd_req_reg     <= '0;
			wr_req_reg     <= '0;
		end else if (i_ce) begin
			host_flags_reg <= (host_flags_reg & ~c_rd_hit) | h_wr_set; // RULE4
			core_flags_reg <= (core_flags_reg & ~h_rd_hit) | c_wr_hit; // RULE5
			wr_req_reg     <= (wr_req_reg & ~c_rd_hit) | h_wr_set; // RULE3
			rd_req_reg     <= (rd_req_reg & ~c_wr_hit) | h_rd_hit; // RULE3
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst || in_reset) begin
			ovwr_reg <= hmp_pkg::OVWR_RESET; // RULE9
		end else if (i_ce) begin
			if (f_apply && (f_idx == hmp_pkg::IDX_MIRROR_CTL)) begin
				ovwr_reg <= f_out_data[hmp_pkg::OVWR_BIT]; // RULE7
			end else if (i_core_wr && cidx[3] && (cidx[2:0] == hmp_pkg::IDX_MIRROR_CTL)) begin
				ovwr_reg <= i_core_wdata[hmp_pkg::OVWR_BIT]; // RULE7
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_read_irq_req  <= 1'b0;
			o_write_irq_req <= 1'b0;
		end else if (i_ce) begin
			o_read_irq_req  <= |rd_req_reg; // RULE3
			o_write_irq_req <= |wr_req_reg; // RULE3
		end
	end

	// ****************************************************************
	// Core read path
	// ****************************************************************
	logic [15:0] core_view6_reg;
	logic [15:0] core_view7_reg;

	// The core sees status one full clock after a change; the copy also
	// keeps the value steady during the core's own read cycle.
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			core_view6_reg <= '0;
			core_view7_reg <= {8'h00, hmp_pkg::OVWR_RESET, 7'h00};
		end else if (i_ce) begin
			core_view6_reg <= sr6; // RULE18
			core_view7_reg <= sr7; // RULE18
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_core_rdata <= '0;
		end else if (i_ce && i_core_rd) begin
			if (!cidx[3]) begin
				o_core_rdata <= '0;
			end else begin
				case (cidx[2:0])
					hmp_pkg::IDX_WR_FLAGS:   o_core_rdata <= core_view6_reg; // RULE14
					hmp_pkg::IDX_MIRROR_CTL: o_core_rdata <= core_view7_reg; // RULE8
					default:                 o_core_rdata <= mbx[cidx[2:0]];
				endcase
			end
		end
	end

endmodule : hmp_top

// ---- verif/hmp_host_model.sv ----
// Behavioural host processor driving the mailbox port's host pins.
`timescale 1ns/100ps
module hmp_host_model (
	// Clock and bus modes
	input  wire logic        i_mclk,
	input  wire logic        i_strobe_mode,
	input  wire logic        i_mux_mode,
	// Answer from the port
	input  wire logic        i_ack,
	input  wire logic [15:0] i_bus,
	input  wire logic [1:0]  i_oe,
	// Host pins
	output logic             o_sel_n,
	output logic             o_rw,
	output logic             o_ds_n,
	output logic             o_ale,
	output logic [1:0]       o_addr,
	output logic [15:0]      o_data
);
	// ****************************************************************
	// Host access
	// ****************************************************************
	initial begin
		o_sel_n = 1'b1;
		o_rw    = 1'b1;
		o_ds_n  = 1'b1;
		o_ale   = 1'b0;
		o_addr  = 2'h0;
		o_data  = 16'h0000;
	end
	task automatic access(input logic wr, input logic [2:0] a, input logic [15:0] wd,
			output logic [15:0] rd, output logic [1:0] oe, output logic ok);
		int n;
		ok = 1'b0;
		rd = 16'h0000;
		oe = 2'b00;
		@(negedge i_mclk);
		if (i_mux_mode) begin
			// Upper bits carry junk, so a decoder using them would miss.
			o_ale  <= 1'b1;
			o_data <= {13'h1fff, a};
			repeat (3) @(negedge i_mclk);
			o_ale  <= 1'b0;
			@(negedge i_mclk);
		end else begin
			o_ale  <= a[2];
			o_addr <= a[1:0];
		end
		o_data  <= wr ? wd : ~o_data;
		o_sel_n <= 1'b0;
		o_rw    <= i_strobe_mode ? !wr : wr;
		o_ds_n  <= i_strobe_mode ? 1'b0 : !wr;
		for (n = 0; n < 200 && !ok; n++) begin
			@(negedge i_mclk);
			if (i_ack === 1'b1) begin
				ok = 1'b1;
				rd = i_bus;
				oe = i_oe;
			end
		end
		@(negedge i_mclk);
		o_sel_n <= 1'b1;
		o_rw    <= 1'b1;
		o_ds_n  <= 1'b1;
		o_ale   <= 1'b0;
		for (n = 0; n < 20 && i_ack !== 1'b0; n++)
			@(negedge i_mclk);
		// Write data is held until the port has seen the strobe go away.
		@(negedge i_mclk);
		o_data <= ~o_data;
	endtask : access
endmodule : hmp_host_model

// ---- verif/hmp_top_chk.sv ----
// Concurrent checks on the host mailbox port top and their bind.
`timescale 1ns/100ps
module hmp_top_chk #(
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input wire logic        i_mclk,
	input wire logic        i_nrst,
	input wire logic        i_ce,
	// Host side
	input wire logic        i_host_sel_n,
	input wire logic [1:0]  o_host_data_oe,
	input wire logic        o_host_acknowledge,
	// Core side
	input wire logic [13:0] i_core_addr,
	input wire logic        i_core_rd,
	input wire logic        i_core_wr,
	input wire logic [15:0] i_core_wdata,
	input wire logic [15:0] o_core_rdata,
	input wire logic        o_read_irq_req,
	input wire logic        o_write_irq_req,
	input wire logic        o_soft_reset
);
	// ****************************************************************
	// Checks
	// ****************************************************************
	localparam logic [13:0] A6 = {hmp_pkg::MBX_BASE_ADDR[13:3], hmp_pkg::IDX_WR_FLAGS};
	localparam logic [13:0] A7 = {hmp_pkg::MBX_BASE_ADDR[13:3], hmp_pkg::IDX_MIRROR_CTL};
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	sequence s_pulse_start;
		$rose(o_soft_reset);
	endsequence
	sequence s_pulse_five;
		o_soft_reset [*5] ##1 !o_soft_reset;
	endsequence
	AST_RST_QUIET: assert property (disable iff (1'b0)
		!i_nrst |=> !o_host_acknowledge && o_host_data_oe == 2'b00)
		else $error("Host pins active after reset");
	AST_RST_REQ: assert property (disable iff (1'b0)
		!i_nrst |=> !o_read_irq_req && !o_write_irq_req && !o_soft_reset)
		else $error("Requests active after reset");
	AST_SWRST_LEN: assert property (s_pulse_start |-> s_pulse_five)
		else $error("Soft reset pulse length wrong");
	AST_SWRST_CAUSE: assert property (
		i_ce && i_core_wr && i_core_addr == A7 && i_core_wdata[hmp_pkg::SWRST_BIT]
		|-> ##[1:2] o_soft_reset) else $error("Soft reset not started");
	AST_CORE_OUT: assert property (
		i_ce && i_core_rd && i_core_addr[13:3] != A6[13:3] |=> o_core_rdata == 16'h0000)
		else $error("Read outside window not zero");
	AST_RD7_ZERO: assert property (
		i_ce && i_core_rd && i_core_addr == A7
		|=> o_core_rdata[15:8] == 8'h00 && !o_core_rdata[6])
		else $error("Reserved or reset bit of second status reads one");
	AST_RD6_ZERO: assert property (
		i_ce && i_core_rd && i_core_addr == A6
		|=> o_core_rdata[15:14] == 2'b00 && o_core_rdata[7:6] == 2'b00)
		else $error("Unused bit of first status reads one");
	AST_ACK_CAUSE: assert property (o_host_acknowledge |-> !$past(i_host_sel_n, 3))
		else $error("Acknowledge without select");
	AST_ACK_DROP: assert property (i_host_sel_n [*3] |=> !o_host_acknowledge)
		else $error("Acknowledge held after release");
	AST_OE_ACK: assert property (o_host_data_oe != 2'b00 |-> o_host_acknowledge)
		else $error("Data driven outside an access");
endmodule : hmp_top_chk

bind hmp_top hmp_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
	.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce), .i_host_sel_n(i_host_sel_n),
	.o_host_data_oe(o_host_data_oe), .o_host_acknowledge(o_host_acknowledge),
	.i_core_addr(i_core_addr), .i_core_rd(i_core_rd), .i_core_wr(i_core_wr),
	.i_core_wdata(i_core_wdata), .o_core_rdata(o_core_rdata),
	.o_read_irq_req(o_read_irq_req), .o_write_irq_req(o_write_irq_req),
	.o_soft_reset(o_soft_reset)
);

// ---- verif/host_mailbox_port_test.sv ----
// Self-checking testbench for the host mailbox port.
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module host_mailbox_port_test;
	// ****************************************************************
	// Bench
	// ****************************************************************
	localparam logic [13:0] B = hmp_pkg::MBX_BASE_ADDR;
	logic        i_mclk = 1'b0;
	logic        i_nrst = 1'b0;
	logic        s8 = 1'b0, sm = 1'b0, mm = 1'b0, crd = 1'b0, cwr = 1'b0;
	logic [13:0] ca = 14'h0000;
	logic [15:0] cwd = 16'h0000, cq, hq, hd, bus;
	logic [1:0]  oe, ha, o;
	logic        sel_n, rw, ds_n, ale, ack, rirq, wirq, srst, ok;
	int          n_errors = 0, compares = 0, cycles = 0, len;
	always #2 i_mclk = ~i_mclk;
	assign bus = {oe[1] ? hq[15:8] : hd[15:8], oe[0] ? hq[7:0] : hd[7:0]};
	hmp_top #(.FIFO_DEPTH(4)) dut (
		.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(1'b1), .i_host_sel_n(sel_n),
		.i_host_rw_select(rw), .i_host_write_strobe_n(ds_n), .i_host_size8(s8),
		.i_host_strobe_mode(sm), .i_host_mux_mode(mm), .i_host_ale_addr2(ale),
		.i_host_addr(ha), .i_host_data(bus), .o_host_data(hq), .o_host_data_oe(oe),
		.o_host_acknowledge(ack), .i_core_addr(ca), .i_core_rd(crd), .i_core_wr(cwr),
		.i_core_wdata(cwd), .o_core_rdata(cq), .o_read_irq_req(rirq),
		.o_write_irq_req(wirq), .o_soft_reset(srst));
	hmp_host_model host (
		.i_mclk(i_mclk), .i_strobe_mode(sm), .i_mux_mode(mm), .i_ack(ack), .i_bus(bus),
		.i_oe(oe), .o_sel_n(sel_n), .o_rw(rw), .o_ds_n(ds_n), .o_ale(ale), .o_addr(ha),
		.o_data(hd));
	task automatic conclude();
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic cw(input logic [13:0] a, input logic [15:0] v);
		@(negedge i_mclk);
		ca  = a;
		cwd = v;
		cwr = 1'b1;
		@(negedge i_mclk);
		cwr = 1'b0;
	endtask : cw
	task automatic crc(input logic [13:0] a, input logic [15:0] e);
		@(negedge i_mclk);
		ca  = a;
		crd = 1'b1;
		@(negedge i_mclk);
		crd = 1'b0;
		`CHK(cq, e)
	endtask : crc
	task automatic hw(input logic [2:0] a, input logic [15:0] v);
		logic [15:0] r;
		host.access(1'b1, a, v, r, o, ok);
		`CHK(ok, 1'b1)
	endtask : hw
	task automatic hrc(input logic [2:0] a, input logic [15:0] e);
		logic [15:0] r;
		host.access(1'b0, a, 16'h0000, r, o, ok);
		`CHK(ok, 1'b1)
		`CHK((s8 ? {8'h00, r[7:0]} : r), e)
	endtask : hrc
	task automatic mode(input int i);
		@(negedge i_mclk);
		sm = i[0];
		mm = i[1];
	endtask : mode
	task automatic t_core_to_host();
		crc(B + 14'h7, 16'h0080);
		crc(14'h3ff0, 16'h0000);
		for (int i = 0; i < 6; i++)
			cw(B + 14'(i), {12'h900, 4'(i)});
		crc(B + 14'h6, 16'h3f00);
		crc(B + 14'h7, 16'h00bf);
		hrc(3'h6, 16'h0000);
		hrc(3'h6, 16'h3f00);
		hrc(3'h7, 16'h00bf);
		for (int i = 0; i < 6; i++) begin
			mode(i);
			hrc(3'(i), {12'h900, 4'(i)});
		end
		mode(0);
		crc(B + 14'h6, 16'h0000);
		`CHK(rirq, 1'b1)
	endtask : t_core_to_host
	task automatic t_host_to_core();
		for (int i = 0; i < 6; i++) begin
			mode(i);
			hw(3'(i), {12'h5a0, 4'(i)});
		end
		mode(0);
		repeat (10) @(negedge i_mclk);
		`CHK(wirq, 1'b1)
		crc(B + 14'h6, 16'h003f);
		for (int i = 0; i < 6; i++)
			crc(B + 14'(i), {12'h5a0, 4'(i)});
		crc(B + 14'h6, 16'h0000);
		`CHK(wirq, 1'b0)
	endtask : t_host_to_core
	task automatic t_hold_off();
		cw(B + 14'h7, 16'h0000);
		crc(B + 14'h7, 16'h0000);
		hw(3'h3, 16'h1111);
		repeat (10) @(negedge i_mclk);
		fork
			hw(3'h3, 16'h2222);
			begin
				repeat (20) @(negedge i_mclk);
				`CHK({ack, sel_n}, 2'b00)
				crc(B + 14'h3, 16'h1111);
			end
		join
		repeat (10) @(negedge i_mclk);
		crc(B + 14'h3, 16'h2222);
		cw(B + 14'h7, 16'h0080);
		hw(3'h4, 16'h3333);
		hw(3'h4, 16'h4444);
		repeat (10) @(negedge i_mclk);
		crc(B + 14'h4, 16'h4444);
	endtask : t_hold_off
	task automatic t_size8();
		@(negedge i_mclk);
		s8 = 1'b1;
		hw(3'h5, 16'habcd);
		hrc(3'h1, 16'h0001);
		`CHK(o, 2'b01)
		@(negedge i_mclk);
		s8 = 1'b0;
		repeat (10) @(negedge i_mclk);
		crc(B + 14'h5, 16'h00cd);
	endtask : t_size8
	task automatic t_resets();
		hw(3'h7, 16'h0000);
		crc(B + 14'h7, 16'h0000);
		cw(B + 14'h7, 16'h0040);
		for (len = 0; len < 10 && srst !== 1'b1; len++)
			@(negedge i_mclk);
		for (len = 0; len < 20 && srst === 1'b1; len++)
			@(negedge i_mclk);
		`CHK(len, 5)
		crc(B + 14'h7, 16'h0080);
		crc(B + 14'h4, 16'h4444);
		hw(3'h0, 16'h7777);
		repeat (10) @(negedge i_mclk);
		i_nrst = 1'b0;
		repeat (4) @(negedge i_mclk);
		`CHK(ack, 1'b0)
		`CHK(oe, 2'b00)
		i_nrst = 1'b1;
		crc(B + 14'h0, 16'h7777);
		crc(B + 14'h6, 16'h0000);
	endtask : t_resets
	initial begin
		repeat (4) @(negedge i_mclk);
		i_nrst = 1'b1;
		repeat (3) @(negedge i_mclk);
		t_core_to_host();
		t_host_to_core();
		t_hold_off();
		t_size8();
		t_resets();
		conclude();
	end
endmodule : host_mailbox_port_test
